// File: common/flag_pkg.sv
/*
 * Constants and carrier types for the CPU condition flag logic.
 * Assumes a single aclk domain and an AXI4-Lite master for register access.
 */
package flag_pkg;

	// flag bit positions
	localparam int V_BIT = 7;
	localparam int H_BIT = 4;
	localparam int I_BIT = 3;
	localparam int N_BIT = 2;
	localparam int Z_BIT = 1;
	localparam int C_BIT = 0;

	// fixed bits 6 and 5
	localparam logic [1:0] FIXED_HI = 2'h3;

	// flag state after reset: mask set, fixed bits high
	localparam logic [7:0] FLAGS_RESET = 8'h68;

	// register map
	localparam int         AXI_ADDR_W   = 4;
	localparam logic [3:0] FLAGS_OFFSET = 4'h0;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		OP_NONE    = 4'h0,
		OP_ADD     = 4'h1,
		OP_ADC     = 4'h2,
		OP_SUB     = 4'h3,
		OP_SBC     = 4'h4,
		OP_LOGIC   = 4'h5,
		OP_LOAD8   = 4'h6,
		OP_LOAD16  = 4'h7,
		OP_DECADJ  = 4'h8,
		OP_SHIFT   = 4'h9,
		OP_BITTEST = 4'hA,
		OP_UNMASK  = 4'hB,
		OP_MASK    = 4'hC
	} op_kind_t;

	// one operation from the execution datapath
	typedef struct packed {
		op_kind_t    kind;
		logic [7:0]  a;
		logic [7:0]  b;
		logic [15:0] wide;
		logic        shift_c;
	} op_req_t;

	// whole block state
	typedef struct packed {
		logic [7:0]            flags;
		logic                  hold;
		logic [7:0]            result;
		logic                  aw_have;
		logic [AXI_ADDR_W-1:0] awaddr_q;
		logic                  w_have;
		logic [7:0]            wdata_q;
		logic                  wstrb0_q;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [7:0]            rdata;
		logic [1:0]            rresp;
	} state_t;

endpackage : flag_pkg

// File: src/cpu_condition_flag_logic.sv
/*
 * Condition flag register, interrupt mask gating and flag update logic
 * for an 8-bit CPU, with an AXI4-Lite view of the flag register.
 * Assumes op_valid pulses once per executed operation, irq_boundary
 * marks each instruction boundary, stack_done pulses when the interrupt
 * entry has pushed the registers. All inputs synchronous to aclk.
 */
// Added by the designer: the register addresses and register access over AXI4-Lite.
module cpu_condition_flag_logic
	import flag_pkg::*;
(
	// clock, reset, enable
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  ce,
	// datapath operation
	input  wire logic                  op_valid,
	input  wire op_req_t               op,
	output logic [7:0]                 result,
	output logic [7:0]                 status_flags,
	// branch conditions
	output logic                       branch_greater,
	output logic                       branch_greater_equal,
	output logic                       branch_less_equal,
	output logic                       branch_less,
	// interrupt sequencing
	input  wire logic                  irq_pending,
	input  wire logic                  irq_boundary,
	input  wire logic                  stack_done,
	output logic                       irq_take,
	// axi4-lite write
	input  wire logic [AXI_ADDR_W-1:0] awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	// axi4-lite read
	input  wire logic [AXI_ADDR_W-1:0] araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready
);

	state_t s_r;
	state_t s_nxt;

	logic [8:0] sum9;
	logic [8:0] diff9;
	logic       half_c;
	logic [8:0] dec9;
	logic       cin;
	logic       add_op;
	logic       sub_op;

	// nibble carry out of bit 3
	function automatic logic nib_carry(input logic [3:0] a,
		input logic [3:0] b, input logic c);
		logic [4:0] t;
		t = {1'b0, a} + {1'b0, b} + {4'h0, c};
		nib_carry = t[4];
	endfunction : nib_carry

	// bcd correction: {carry, adjusted value}
	function automatic logic [8:0] dec_adjust(input logic [7:0] a,
		input logic h, input logic c);
		logic       lo_fix;
		logic       hi_fix;
		logic [7:0] corr;
		lo_fix = h || (a[3:0] > 4'h9);
		hi_fix = c || (a[7:4] > 4'h9)
			|| ((a[7:4] >= 4'h9) && (a[3:0] > 4'h9));
		corr = {(hi_fix ? 4'h6 : 4'h0), (lo_fix ? 4'h6 : 4'h0)};
		dec_adjust = {hi_fix, a + corr};
	endfunction : dec_adjust

	// signed overflow for add or subtract
	function automatic logic ovf(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] r, input logic is_sub);
		ovf = is_sub ? ((a[7] != b[7]) && (r[7] != a[7]))
			: ((a[7] == b[7]) && (r[7] != a[7]));
	endfunction : ovf

	assign add_op = (op.kind == OP_ADD) || (op.kind == OP_ADC);
	assign sub_op = (op.kind == OP_SUB) || (op.kind == OP_SBC);
	assign cin    = ((op.kind == OP_ADC) || (op.kind == OP_SBC))
		&& s_r.flags[C_BIT];
	assign sum9   = {1'b0, op.a} + {1'b0, op.b} + {8'h00, cin};
	assign diff9  = {1'b0, op.a} - {1'b0, op.b} - {8'h00, cin};
	assign half_c = nib_carry(op.a[3:0], op.b[3:0], cin);
	assign dec9   = dec_adjust(op.a, s_r.flags[H_BIT], s_r.flags[C_BIT]);

	always_comb begin
		s_nxt = s_r;
		// instruction boundary ends the post-unmask shadow
		if (irq_boundary && s_r.hold) begin
			s_nxt.hold = 1'b0;
		end
		// write channel capture, either order
		if (awvalid && awready) begin
			s_nxt.aw_have  = 1'b1;
			s_nxt.awaddr_q = awaddr;
		end
		if (wvalid && wready) begin
			s_nxt.w_have   = 1'b1;
			s_nxt.wdata_q  = wdata[7:0];
			s_nxt.wstrb0_q = wstrb[0];
		end
		if (s_r.bvalid && bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.aw_have && s_r.w_have) begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have  = 1'b0;
			s_nxt.bvalid  = 1'b1;
			if (s_r.awaddr_q == FLAGS_OFFSET) begin
				s_nxt.bresp = RESP_OKAY;
				if (s_r.wstrb0_q) begin
					s_nxt.flags = s_r.wdata_q;
					if (s_r.flags[I_BIT] && !s_r.wdata_q[I_BIT]) begin
						s_nxt.hold = 1'b1;
					end
				end
			end else begin
				s_nxt.bresp = RESP_SLVERR;
			end
		end
		// read channel
		if (s_r.rvalid && rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			s_nxt.rvalid = 1'b1;
			if (araddr == FLAGS_OFFSET) begin
				s_nxt.rdata = s_r.flags;
				s_nxt.rresp = RESP_OKAY;
			end else begin
				s_nxt.rdata = 8'h00;
				s_nxt.rresp = RESP_SLVERR;
			end
		end
		// datapath flag updates override a same-cycle bus write
		if (op_valid) begin
			case (op.kind)
				OP_ADD, OP_ADC: begin
					s_nxt.result        = sum9[7:0];
					s_nxt.flags[H_BIT]  = half_c;
					s_nxt.flags[C_BIT]  = sum9[8];
					s_nxt.flags[V_BIT]  = ovf(op.a, op.b, sum9[7:0],
						1'b0);
					s_nxt.flags[N_BIT]  = sum9[7];
					s_nxt.flags[Z_BIT]  = (sum9[7:0] == 8'h00);
				end
				OP_SUB, OP_SBC: begin
					s_nxt.result        = diff9[7:0];
					s_nxt.flags[C_BIT]  = diff9[8];
					s_nxt.flags[V_BIT]  = ovf(op.a, op.b, diff9[7:0],
						1'b1);
					s_nxt.flags[N_BIT]  = diff9[7];
					s_nxt.flags[Z_BIT]  = (diff9[7:0] == 8'h00);
				end
				OP_DECADJ: begin
					s_nxt.result        = dec9[7:0];
					s_nxt.flags[C_BIT]  = dec9[8];
					s_nxt.flags[N_BIT]  = dec9[7];
					s_nxt.flags[Z_BIT]  = (dec9[7:0] == 8'h00);
				end
				OP_LOGIC: begin
					s_nxt.result        = op.a;
					s_nxt.flags[V_BIT]  = 1'b0;
					s_nxt.flags[N_BIT]  = op.a[7];
					s_nxt.flags[Z_BIT]  = (op.a == 8'h00);
				end
				OP_LOAD8: begin
					s_nxt.result        = op.a;
					s_nxt.flags[V_BIT]  = 1'b0;
					s_nxt.flags[N_BIT]  = op.a[7];
					s_nxt.flags[Z_BIT]  = (op.a == 8'h00);
				end
				OP_LOAD16: begin
					s_nxt.result        = op.wide[7:0];
					s_nxt.flags[V_BIT]  = 1'b0;
					s_nxt.flags[N_BIT]  = op.wide[15];
					s_nxt.flags[Z_BIT]  = (op.wide == 16'h0000);
				end
				OP_SHIFT: begin
					s_nxt.result        = op.a;
					s_nxt.flags[C_BIT]  = op.shift_c;
					s_nxt.flags[N_BIT]  = op.a[7];
					s_nxt.flags[Z_BIT]  = (op.a == 8'h00);
					s_nxt.flags[V_BIT]  = op.a[7] ^ op.shift_c;
				end
				OP_BITTEST: begin
					s_nxt.flags[C_BIT]  = op.shift_c;
				end
				OP_UNMASK: begin
					s_nxt.flags[I_BIT]  = 1'b0;
					if (s_r.flags[I_BIT]) begin
						s_nxt.hold = 1'b1;
					end
				end
				OP_MASK: begin
					s_nxt.flags[I_BIT]  = 1'b1;
				end
				default: begin
					s_nxt.result = s_r.result;
				end
			endcase
		end
		// interrupt entry mask set wins over any clear
		if (stack_done) begin
			s_nxt.flags[I_BIT] = 1'b1;
		end
		s_nxt.flags[6:5] = FIXED_HI;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r       <= '0;
			s_r.flags <= FLAGS_RESET;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// outputs
	assign result       = s_r.result;
	assign status_flags = s_r.flags;
	// bus looks stalled while frozen, so no handshake is lost
	assign awready      = ce && !s_r.aw_have && !s_r.bvalid;
	assign wready       = ce && !s_r.w_have && !s_r.bvalid;
	assign bvalid       = ce && s_r.bvalid;
	assign bresp        = s_r.bresp;
	assign arready      = ce && !s_r.rvalid;
	assign rvalid       = ce && s_r.rvalid;
	assign rresp        = s_r.rresp;
	assign rdata        = {24'h000000, s_r.rdata};

	// signed compares use N xor V
	assign branch_greater_equal = !(s_r.flags[N_BIT] ^ s_r.flags[V_BIT]);
	assign branch_less          = s_r.flags[N_BIT] ^ s_r.flags[V_BIT];
	assign branch_greater       = branch_greater_equal && !s_r.flags[Z_BIT];
	assign branch_less_equal    = branch_less || s_r.flags[Z_BIT];

	assign irq_take = ce && irq_boundary && irq_pending
		&& !s_r.flags[I_BIT]
		&& !s_r.hold;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);

	sequence add_seq;
		ce && op_valid && add_op;
	endsequence

	sequence unmask_seq;
		ce && op_valid && (op.kind == OP_UNMASK) && s_r.flags[I_BIT]
			&& !stack_done;
	endsequence

	sequence shadow_seq;
		(unmask_seq ##1 irq_boundary)
			or (unmask_seq ##1 !irq_boundary ##1 irq_boundary);
	endsequence

	add_carry_a: assert property (add_seq |=>
		status_flags[C_BIT] == $past(sum9[8]))
		else $error("carry flag wrong after add");

	half_carry_a: assert property (add_seq |=>
		status_flags[H_BIT] == $past(half_c))
		else $error("half carry flag wrong after add");

	overflow_a: assert property (ce && op_valid && sub_op |=>
		status_flags[V_BIT] == (($past(op.a[7]) != $past(op.b[7]))
		&& (result[7] != $past(op.a[7]))))
		else $error("overflow flag wrong after subtract");

	sign_zero_a: assert property (ce && op_valid
		&& (op.kind == OP_LOGIC) |=>
		status_flags[N_BIT] == $past(op.a[7])
		&& status_flags[Z_BIT] == ($past(op.a) == 8'h00))
		else $error("sign or zero flag mismatch with result");

	load16_nz_a: assert property (ce && op_valid
		&& (op.kind == OP_LOAD16) |=>
		status_flags[Z_BIT] == ($past(op.wide) == 16'h0000)
		&& status_flags[N_BIT] == $past(op.wide[15]))
		else $error("wide load flags wrong");

	dec_adjust_a: assert property (ce && op_valid
		&& (op.kind == OP_DECADJ) |=> result == $past(dec9[7:0])
		&& status_flags[C_BIT] == $past(dec9[8]))
		else $error("decimal adjust result wrong");

	mask_block_a: assert property (status_flags[I_BIT] |-> !irq_take)
		else $error("interrupt taken while masked");

	mask_entry_a: assert property (ce && stack_done |=>
		status_flags[I_BIT])
		else $error("mask not set on interrupt entry");

	unmask_shadow_a: assert property (shadow_seq |-> !irq_take)
		else $error("interrupt at boundary after unmask");

	shift_carry_a: assert property (ce && op_valid
		&& (op.kind == OP_SHIFT || op.kind == OP_BITTEST) |=>
		status_flags[C_BIT] == $past(op.shift_c))
		else $error("shift carry not updated");

	fixed_bits_a: assert property (ce ##1 1'b1 |->
		status_flags[6:5] == FIXED_HI)
		else $error("fixed flag bits changed");

	frozen_state_a: assert property (@(posedge aclk)
		disable iff (!aresetn) !ce |=>
		status_flags == $past(status_flags) && result == $past(result))
		else $error("state changed while clock enable low");

	frozen_take_a: assert property (@(posedge aclk)
		disable iff (!aresetn) !ce |-> !irq_take)
		else $error("interrupt taken while clock enable low");

endmodule : cpu_condition_flag_logic

// File: tb/cpu_condition_flag_logic_tb.sv
/*
 * Self-checking bench for the condition flag block: datapath operations,
 * interrupt gating and the AXI4-Lite view of the flag register.
 * Assumes flag_pkg and the design module are compiled before it.
 */
module cpu_condition_flag_logic_tb import flag_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic                  aclk, aresetn, op_valid, irq_take, ce;
	logic                  irq_pending, irq_boundary, stack_done;
	op_req_t               op;
	logic [7:0]            result, status_flags;
	logic                  branch_greater, branch_greater_equal;
	logic                  branch_less_equal, branch_less;
	logic [AXI_ADDR_W-1:0] awaddr, araddr;
	logic                  awvalid, awready, wvalid, wready, bvalid;
	logic                  bready, arvalid, arready, rvalid, rready;
	logic [31:0]           wdata, rdata, rd_v;
	logic [3:0]            wstrb;
	logic [1:0]            bresp, rresp, rsp;
	int                    miscompares, checks_done, cycles;

	cpu_condition_flag_logic dut_u (.aclk, .aresetn, .ce, .op_valid,
		.op, .result, .status_flags, .branch_greater, .branch_greater_equal,
		.branch_less_equal, .branch_less, .irq_pending, .irq_boundary,
		.stack_done, .irq_take, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready);

	initial begin
		aclk = 0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up

	// hang guard
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] got, exp, mask);
		checks_done++;
		if ((got & mask) !== (exp & mask)) begin
			miscompares++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic op_chk(input op_kind_t k, input logic [7:0] a, b,
			input logic [15:0] w, input logic sc, input logic [7:0] m, e);
		@(posedge aclk);
		op_valid <= 1'b1;
		op       <= op_req_t'{k, a, b, w, sc};
		@(posedge aclk);
		op_valid <= 1'b0;
		#1 chk({24'h0, status_flags}, {24'h0, e}, {24'h0, m});
	endtask : op_chk

	// gt, ge, le, lt packed high to low
	task automatic br_chk(input logic [3:0] e);
		chk({28'h0, branch_greater, branch_greater_equal, branch_less_equal,
			branch_less}, {28'h0, e}, 32'hF);
	endtask : br_chk

	task automatic bnd(input logic e);
		@(posedge aclk);
		irq_boundary <= 1'b1;
		#1 chk({31'h0, irq_take}, {31'h0, e}, 32'h1);
		@(posedge aclk);
		irq_boundary <= 1'b0;
	endtask : bnd

	task automatic axi_wr(input logic [3:0] ad, input logic [31:0] d,
			input logic [3:0] s);
		logic a_d, w_d;
		a_d = 0;
		w_d = 0;
		@(posedge aclk);
		awaddr  <= ad;
		awvalid <= 1'b1;
		wdata   <= d;
		wstrb   <= s;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!(a_d && w_d)) begin
			@(posedge aclk);
			if (awready === 1'b1 && !a_d) begin
				a_d = 1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1 && !w_d) begin
				w_d = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] ad);
		@(posedge aclk);
		araddr  <= ad;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rd_v = rdata;
		rsp  = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	initial begin
		{aresetn, op_valid, irq_pending, irq_boundary, stack_done} = '0;
		ce = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		op = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{miscompares, checks_done, cycles} = '0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;

		axi_rd(FLAGS_OFFSET);
		chk(rd_v, 32'h68, 32'hFFFFFFFF);
		$display("test reset done");

		op_chk(OP_ADD, 8'h08, 8'h08, 16'h0, 1'b0, 8'h97, 8'h10);
		op_chk(OP_ADD, 8'h7F, 8'h01, 16'h0, 1'b0, 8'h97, 8'hD4);
		br_chk(4'hC);
		op_chk(OP_ADD, 8'hFF, 8'h01, 16'h0, 1'b0, 8'h97, 8'h13);
		op_chk(OP_ADC, 8'h0E, 8'h01, 16'h0, 1'b0, 8'h97, 8'h10);
		chk(result, 8'h10, 32'hFF);
		op_chk(OP_SUB, 8'h00, 8'h01, 16'h0, 1'b0, 8'h87, 8'h05);
		br_chk(4'h3);
		op_chk(OP_SBC, 8'h80, 8'h00, 16'h0, 1'b0, 8'h87, 8'h80);
		op_chk(OP_LOAD8, 8'h00, 8'h00, 16'h0, 1'b0, 8'h86, 8'h02);
		op_chk(OP_LOAD16, 8'h00, 8'h00, 16'h8000, 1'b0, 8'h86, 8'h04);
		op_chk(OP_LOAD16, 8'h00, 8'h00, 16'h0000, 1'b0, 8'h06, 8'h02);
		op_chk(OP_LOGIC, 8'h80, 8'h00, 16'h0, 1'b0, 8'h86, 8'h04);
		op_chk(OP_SHIFT, 8'h00, 8'h00, 16'h0, 1'b1, 8'h03, 8'h03);
		op_chk(OP_BITTEST, 8'h01, 8'h00, 16'h0, 1'b0, 8'h01, 8'h00);
		ce <= 1'b0;
		op_chk(OP_ADD, 8'h01, 8'h01, 16'h0, 1'b0, 8'h97, 8'h92);
		chk(result, 8'h00, 32'hFF);
		ce <= 1'b1;
		$display("test arith done");

		op_chk(OP_ADD, 8'h19, 8'h28, 16'h0, 1'b0, 8'h11, 8'h10);
		op_chk(OP_DECADJ, 8'h41, 8'h00, 16'h0, 1'b0, 8'h00, 8'h00);
		chk(result, 8'h47, 32'hFF);
		op_chk(OP_ADD, 8'h55, 8'h55, 16'h0, 1'b0, 8'h11, 8'h00);
		op_chk(OP_DECADJ, 8'hAA, 8'h00, 16'h0, 1'b0, 8'h01, 8'h01);
		chk(result, 8'h10, 32'hFF);
		$display("test decimal done");

		irq_pending <= 1'b1;
		bnd(1'b0);
		op_chk(OP_UNMASK, 8'h00, 8'h00, 16'h0, 1'b0, 8'h08, 8'h00);
		bnd(1'b0);
		bnd(1'b1);
		ce <= 1'b0;
		bnd(1'b0);
		ce <= 1'b1;
		@(posedge aclk);
		stack_done <= 1'b1;
		@(posedge aclk);
		stack_done <= 1'b0;
		#1 chk({24'h0, status_flags}, 32'h08, 32'h08);
		bnd(1'b0);
		op_chk(OP_UNMASK, 8'h00, 8'h00, 16'h0, 1'b0, 8'h08, 8'h00);
		op_chk(OP_MASK, 8'h00, 8'h00, 16'h0, 1'b0, 8'h08, 8'h08);
		bnd(1'b0);
		irq_pending <= 1'b0;
		$display("test irq done");

		axi_wr(FLAGS_OFFSET, 32'h0, 4'hF);
		chk({30'h0, rsp}, {30'h0, RESP_OKAY}, 32'h3);
		irq_pending <= 1'b1;
		bnd(1'b0);
		bnd(1'b1);
		irq_pending <= 1'b0;
		axi_rd(FLAGS_OFFSET);
		chk(rd_v, 32'h60, 32'hFFFFFFFF);
		axi_wr(FLAGS_OFFSET, 32'hFF, 4'hF);
		axi_wr(FLAGS_OFFSET, 32'h0, 4'h0);
		axi_rd(FLAGS_OFFSET);
		chk(rd_v, 32'hFF, 32'hFFFFFFFF);
		axi_wr(4'h4, 32'h0, 4'hF);
		chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, 32'h3);
		axi_rd(4'h4);
		chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, 32'h3);
		$display("test bus done");
		wrap_up();
	end
endmodule : cpu_condition_flag_logic_tb
